/* File: rtl/tmr16_pkg.sv */
// constants for the sixteen-bit timer core
package tmr16_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int CNT_W  = 16;
	// byte addresses of the register map
	localparam logic [4:0] CTRL_A = 5'h00;
	localparam logic [4:0] CTRL_B = 5'h01;
	localparam logic [4:0] CTRL_C = 5'h02;
	localparam logic [4:0] CNT_L  = 5'h04;
	localparam logic [4:0] CNT_H  = 5'h05;
	localparam logic [4:0] CAP_L  = 5'h06;
	localparam logic [4:0] CAP_H  = 5'h07;
	localparam logic [4:0] CMPA_L = 5'h08;
	localparam logic [4:0] CMPA_H = 5'h09;
	localparam logic [4:0] CMPB_L = 5'h0a;
	localparam logic [4:0] CMPB_H = 5'h0b;
	localparam logic [4:0] CMPC_L = 5'h0c;
	localparam logic [4:0] CMPC_H = 5'h0d;
	localparam logic [4:0] FLAG   = 5'h0e;
	localparam logic [4:0] MASK   = 5'h0f;
	localparam logic [4:0] POWER  = 5'h10;
	// field positions
	localparam int CA_TOP_LSB  = 0;
	localparam int CA_PWM_BIT  = 3;
	localparam int CA_DUAL_BIT = 4;
	localparam int CB_CS_LSB   = 0;
	localparam int CB_EDGE_BIT = 6;
	localparam int CB_NC_BIT   = 7;
	localparam int CC_ACMP_BIT = 0;
	localparam int FL_OVF      = 0;
	localparam int FL_CMPA     = 1;
	localparam int FL_CAP      = 5;
	localparam int PG_BIT      = 0;
	localparam logic [7:0] FLAG_BITS = 8'h2f;
	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam logic [7:0] POWER_RST = 8'h00;
	// top selection codes and fixed values
	localparam logic [2:0] TOP_MAX  = 3'h0;
	localparam logic [2:0] TOP_FIX8 = 3'h1;
	localparam logic [2:0] TOP_FIX9 = 3'h2;
	localparam logic [2:0] TOP_FIXA = 3'h3;
	localparam logic [2:0] TOP_CMPA = 3'h4;
	localparam logic [2:0] TOP_CAP  = 3'h5;
	localparam logic [15:0] BOTTOM_VAL = 16'h0000;
	localparam logic [15:0] MAX_VAL    = 16'hffff;
	localparam logic [15:0] FIX8_VAL   = 16'h00ff;
	localparam logic [15:0] FIX9_VAL   = 16'h01ff;
	localparam logic [15:0] FIXA_VAL   = 16'h03ff;
	// clock select codes and prescaler tap widths
	localparam logic [2:0] CS_NONE = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_D64  = 3'h3;
	localparam logic [2:0] CS_D256 = 3'h4;
	localparam logic [2:0] CS_D1K  = 3'h5;
	localparam logic [2:0] CS_FALL = 3'h6;
	localparam int PRE_SH_8   = 3;
	localparam int PRE_SH_64  = 6;
	localparam int PRE_SH_256 = 8;
	localparam int PRE_SH_1K  = 10;
	localparam int NC_SAMPLES = 4;
	typedef enum logic {TMR16_UP, TMR16_DOWN} tmr16_dir_type;
endpackage

/* File: rtl/tmr16_clk_sel.sv */
// timer clock selection: prescaler taps and external pin edges
`timescale 1ns/1ps
module tmr16_clk_sel #(
	parameter int PRE_W = tmr16_pkg::PRE_SH_1K
) (
	input  wire logic       clk_sys_in,
	input  wire logic       arst_n_in,
	input  wire logic [2:0] clk_sel_in,
	input  wire logic       ext_count_pin_in,
	output logic            timer_tick_out
);
	logic [PRE_W-1:0] pre_reg;
	logic [PRE_W-1:0] pre_next;
	logic             sync1_reg;
	logic             sync2_reg;
	logic             last_reg;
	logic             tick_reg;
	logic             tick_next;

	always_comb begin
		pre_next = pre_reg + {{(PRE_W-1){1'b0}}, 1'b1};
		case (clk_sel_in)
			tmr16_pkg::CS_NONE: tick_next = 1'b0;
			tmr16_pkg::CS_DIV1: tick_next = 1'b1;
			tmr16_pkg::CS_DIV8: tick_next = &pre_reg[tmr16_pkg::PRE_SH_8-1:0];
			tmr16_pkg::CS_D64:  tick_next = &pre_reg[tmr16_pkg::PRE_SH_64-1:0];
			tmr16_pkg::CS_D256: tick_next = &pre_reg[tmr16_pkg::PRE_SH_256-1:0];
			tmr16_pkg::CS_D1K:  tick_next = &pre_reg[tmr16_pkg::PRE_SH_1K-1:0];
			tmr16_pkg::CS_FALL: tick_next = last_reg & ~sync2_reg;
			default:            tick_next = sync2_reg & ~last_reg;
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pre_reg   <= '0;
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			last_reg  <= 1'b0;
			tick_reg  <= 1'b0;
		end else begin
			pre_reg   <= pre_next;
			sync1_reg <= ext_count_pin_in;
			sync2_reg <= sync1_reg;
			last_reg  <= sync2_reg;
			tick_reg  <= tick_next;
		end
	end

	assign timer_tick_out = tick_reg;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!arst_n_in);
	no_src_tick_a: assert property ($past(clk_sel_in) == tmr16_pkg::CS_NONE |-> !timer_tick_out)
		else $error("tick with no clock source");
endmodule // tmr16_clk_sel

/* File: rtl/tmr16_cap_in.sv */
// capture trigger: sync, noise filter and edge detect
`timescale 1ns/1ps
module tmr16_cap_in #(
	parameter int NC = tmr16_pkg::NC_SAMPLES
) (
	input  wire logic clk_sys_in,
	input  wire logic arst_n_in,
	input  wire logic capture_pin_in,
	input  wire logic comparator_in,
	input  wire logic use_comparator_in,
	input  wire logic filter_on_in,
	input  wire logic rising_in,
	output logic      capture_evt_out
);
	logic [1:0]    pin_sync_reg;
	logic [1:0]    cmp_sync_reg;
	logic [NC-1:0] samp_reg;
	logic [NC-1:0] samp_next;
	logic          filt_reg;
	logic          filt_next;
	logic          evt_reg;
	logic          evt_next;
	logic          src;

	always_comb begin
		src       = use_comparator_in ? cmp_sync_reg[1] : pin_sync_reg[1];
		samp_next = {samp_reg[NC-2:0], src};
		filt_next = src;
		if (filter_on_in) begin
			filt_next = (&samp_reg) ? 1'b1 : (|samp_reg) ? filt_reg : 1'b0;
		end
		evt_next = rising_in ? (filt_next & ~filt_reg) : (filt_reg & ~filt_next);
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pin_sync_reg <= 2'h0;
			cmp_sync_reg <= 2'h0;
			samp_reg     <= '0;
			filt_reg     <= 1'b0;
			evt_reg      <= 1'b0;
		end else begin
			pin_sync_reg <= {pin_sync_reg[0], capture_pin_in};
			cmp_sync_reg <= {cmp_sync_reg[0], comparator_in};
			samp_reg     <= samp_next;
			filt_reg     <= filt_next;
			evt_reg      <= evt_next;
		end
	end

	assign capture_evt_out = evt_reg;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!arst_n_in);
	evt_edge_a: assert property (capture_evt_out |-> filt_reg != $past(filt_reg))
		else $error("capture event without filtered edge");
endmodule // tmr16_cap_in

/* File: rtl/tmr16_core.sv */
// sixteen-bit timer core with byte access, compare and capture
`timescale 1ns/1ps
// Functional notes
// - counter, compares and capture are 16 bits; controls are 8 bits, free access
// - counter holds when no clock source is selected
// - tick comes from prescaler or external pin with selected edge
// - three buffered compares checked on each timer tick except the first one after a counter write, driving compare output pins
// - a compare match sets that channel's match flag
// - selected capture edge latches counter unless capture register is top; optional noise filter before edge detect
// - top is 0xffff, 0x00ff, 0x01ff, 0x03ff, compare A or capture register
// - compare A as top in pwm: no channel A output, top double buffered
// - bottom when counter is 0x0000, max when 0xffff
// - one 8-bit temporary high byte shared by all 16-bit registers
// - low byte write loads temporary and low byte together; capture register only when it is top
// - low byte read copies high byte into temporary in same cycle
// - compare reads bypass the temporary byte
// - five flag sources: overflow, three matches, capture
// - flags in one flag register, each gated by its mask bit
// - counter high-byte location reaches only the temporary byte
// - counter write beats counting in the same cycle
module tmr16_core (
	input  wire logic       clk_sys_in,
	input  wire logic       arst_n_in,
	input  wire logic [4:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic      [7:0] rdata_out,
	input  wire logic       ext_count_pin_in,
	input  wire logic       capture_pin_in,
	input  wire logic       comparator_in,
	output logic      [2:0] compare_out_pins_out,
	output logic      [7:0] irq_req_out,
	output logic            count_bottom_out,
	output logic            count_max_out
);
	logic [7:0]               ctrl_a_reg, ctrl_a_next;
	logic [7:0]               ctrl_b_reg, ctrl_b_next;
	logic [7:0]               ctrl_c_reg, ctrl_c_next;
	logic [15:0]              count_reg, count_next;
	logic [15:0]              capture_reg, capture_next;
	logic [15:0]              cmp_buf_reg [3];
	logic [15:0]              cmp_buf_next [3];
	logic [15:0]              cmp_act_reg [3];
	logic [15:0]              cmp_act_next [3];
	logic [7:0]               temp_reg, temp_next;
	logic [7:0]               flag_reg, flag_next;
	logic [7:0]               mask_reg, mask_next;
	logic [7:0]               power_reg, power_next;
	logic [7:0]               rdata_reg, rdata_next;
	logic [7:0]               irq_reg, irq_next;
	logic [2:0]               pin_reg, pin_next;
	logic                     block_reg, block_next;
	tmr16_pkg::tmr16_dir_type dir_reg, dir_next;
	logic                     timer_tick;
	logic                     cap_evt;
	logic                     gate;
	logic                     run;
	logic                     pwm;
	logic                     dual;
	logic [2:0]               top_sel;
	logic [15:0]              top_val;
	logic                     cnt_wr;
	logic                     cap_ok;
	logic [2:0]               match;
	logic [7:0]               set_bits;

	////////////////////////////////////////////////////////////////////////
	// clock source and capture trigger
	tmr16_clk_sel u_clk_sel (
		.clk_sys_in       (clk_sys_in),
		.arst_n_in        (arst_n_in),
		.clk_sel_in       (ctrl_b_reg[tmr16_pkg::CB_CS_LSB +: 3]),
		.ext_count_pin_in (ext_count_pin_in),
		.timer_tick_out   (timer_tick)
	);

	tmr16_cap_in u_cap_in (
		.clk_sys_in        (clk_sys_in),
		.arst_n_in         (arst_n_in),
		.capture_pin_in    (capture_pin_in),
		.comparator_in     (comparator_in),
		.use_comparator_in (ctrl_c_reg[tmr16_pkg::CC_ACMP_BIT]),
		.filter_on_in      (ctrl_b_reg[tmr16_pkg::CB_NC_BIT]),
		.rising_in         (ctrl_b_reg[tmr16_pkg::CB_EDGE_BIT]),
		.capture_evt_out   (cap_evt)
	);

	////////////////////////////////////////////////////////////////////////
	// mode decode and compare
	assign gate    = power_reg[tmr16_pkg::PG_BIT];
	assign run     = timer_tick & ~gate;
	assign pwm     = ctrl_a_reg[tmr16_pkg::CA_PWM_BIT];
	assign dual    = ctrl_a_reg[tmr16_pkg::CA_DUAL_BIT];
	assign top_sel = ctrl_a_reg[tmr16_pkg::CA_TOP_LSB +: 3];
	assign cnt_wr  = wr_in & (addr_in == tmr16_pkg::CNT_L);
	assign cap_ok  = cap_evt & ~gate & (top_sel != tmr16_pkg::TOP_CAP);

	always_comb begin
		case (top_sel)
			tmr16_pkg::TOP_FIX8: top_val = tmr16_pkg::FIX8_VAL;
			tmr16_pkg::TOP_FIX9: top_val = tmr16_pkg::FIX9_VAL;
			tmr16_pkg::TOP_FIXA: top_val = tmr16_pkg::FIXA_VAL;
			tmr16_pkg::TOP_CMPA: top_val = cmp_act_reg[0];
			tmr16_pkg::TOP_CAP:  top_val = capture_reg;
			default:             top_val = tmr16_pkg::MAX_VAL;
		endcase
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_chan
			assign match[g] = run & ~block_reg & (count_reg == cmp_act_reg[g]);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		ctrl_a_next  = ctrl_a_reg;
		ctrl_b_next  = ctrl_b_reg;
		ctrl_c_next  = ctrl_c_reg;
		count_next   = count_reg;
		capture_next = capture_reg;
		cmp_buf_next = cmp_buf_reg;
		cmp_act_next = cmp_act_reg;
		temp_next    = temp_reg;
		mask_next    = mask_reg;
		power_next   = power_reg;
		dir_next     = dir_reg;
		block_next   = block_reg & ~run;
		rdata_next   = 8'h00;
		set_bits     = 8'h00;
		pin_next     = pin_reg;
		// counting
		if (run) begin
			if (dual) begin
				if (dir_reg == tmr16_pkg::TMR16_UP) begin
					if (count_reg >= top_val) begin
						dir_next   = tmr16_pkg::TMR16_DOWN;
						count_next = count_reg - 16'h0001;
					end else begin
						count_next = count_reg + 16'h0001;
					end
				end else if (count_reg == tmr16_pkg::BOTTOM_VAL) begin
					dir_next                   = tmr16_pkg::TMR16_UP;
					count_next                 = count_reg + 16'h0001;
					set_bits[tmr16_pkg::FL_OVF] = 1'b1;
				end else begin
					count_next = count_reg - 16'h0001;
				end
			end else if (count_reg == top_val) begin
				count_next                 = tmr16_pkg::BOTTOM_VAL;
				set_bits[tmr16_pkg::FL_OVF] = 1'b1;
			end else begin
				count_next = count_reg + 16'h0001;
			end
			if (pwm && count_reg == top_val) begin
				cmp_act_next = cmp_buf_reg;
			end
		end
		for (int i = 0; i < 3; i++) begin
			set_bits[tmr16_pkg::FL_CMPA + i] = match[i];
			if (pwm) begin
				pin_next[i] = count_reg < cmp_act_reg[i];
			end else if (match[i]) begin
				pin_next[i] = ~pin_reg[i];
			end
		end
		if (pwm && top_sel == tmr16_pkg::TOP_CMPA) begin
			pin_next[0] = 1'b0;
		end
		// capture
		if (cap_ok) begin
			capture_next                = count_reg;
			set_bits[tmr16_pkg::FL_CAP] = 1'b1;
		end
		flag_next = flag_reg;
		// bus writes
		if (wr_in) begin
			case (addr_in)
				tmr16_pkg::CTRL_A: ctrl_a_next = wdata_in;
				tmr16_pkg::CTRL_B: ctrl_b_next = wdata_in;
				tmr16_pkg::CTRL_C: ctrl_c_next = wdata_in;
				tmr16_pkg::CNT_H, tmr16_pkg::CAP_H, tmr16_pkg::CMPA_H,
				tmr16_pkg::CMPB_H, tmr16_pkg::CMPC_H: temp_next = wdata_in;
				tmr16_pkg::CNT_L: begin
					count_next = {temp_reg, wdata_in};
					block_next = 1'b1;
				end
				tmr16_pkg::CAP_L: begin
					if (top_sel == tmr16_pkg::TOP_CAP) begin
						capture_next = {temp_reg, wdata_in};
					end
				end
				tmr16_pkg::CMPA_L: cmp_buf_next[0] = {temp_reg, wdata_in};
				tmr16_pkg::CMPB_L: cmp_buf_next[1] = {temp_reg, wdata_in};
				tmr16_pkg::CMPC_L: cmp_buf_next[2] = {temp_reg, wdata_in};
				tmr16_pkg::FLAG:   flag_next = flag_reg & ~(wdata_in & tmr16_pkg::FLAG_BITS);
				tmr16_pkg::MASK:   mask_next = wdata_in & tmr16_pkg::FLAG_BITS;
				tmr16_pkg::POWER:  power_next = wdata_in & 8'h01;
				default:           power_next = power_reg;
			endcase
		end
		flag_next = flag_next | set_bits;
		if (!pwm) begin
			cmp_act_next = cmp_buf_next;
		end
		// bus reads
		if (rd_in) begin
			case (addr_in)
				tmr16_pkg::CTRL_A: rdata_next = ctrl_a_reg;
				tmr16_pkg::CTRL_B: rdata_next = ctrl_b_reg;
				tmr16_pkg::CTRL_C: rdata_next = ctrl_c_reg;
				tmr16_pkg::CNT_L: begin
					rdata_next = count_reg[7:0];
					temp_next  = count_reg[15:8];
				end
				tmr16_pkg::CAP_L: begin
					rdata_next = capture_reg[7:0];
					temp_next  = capture_reg[15:8];
				end
				tmr16_pkg::CNT_H, tmr16_pkg::CAP_H: rdata_next = temp_reg;
				tmr16_pkg::CMPA_L: rdata_next = cmp_buf_reg[0][7:0];
				tmr16_pkg::CMPA_H: rdata_next = cmp_buf_reg[0][15:8];
				tmr16_pkg::CMPB_L: rdata_next = cmp_buf_reg[1][7:0];
				tmr16_pkg::CMPB_H: rdata_next = cmp_buf_reg[1][15:8];
				tmr16_pkg::CMPC_L: rdata_next = cmp_buf_reg[2][7:0];
				tmr16_pkg::CMPC_H: rdata_next = cmp_buf_reg[2][15:8];
				tmr16_pkg::FLAG:   rdata_next = flag_reg;
				tmr16_pkg::MASK:   rdata_next = mask_reg;
				tmr16_pkg::POWER:  rdata_next = power_reg;
				default:           rdata_next = 8'h00;
			endcase
		end
		irq_next = flag_next & mask_next;
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl_a_reg  <= tmr16_pkg::CTRL_RST;
			ctrl_b_reg  <= tmr16_pkg::CTRL_RST;
			ctrl_c_reg  <= tmr16_pkg::CTRL_RST;
			count_reg   <= tmr16_pkg::BOTTOM_VAL;
			capture_reg <= tmr16_pkg::BOTTOM_VAL;
			for (int i = 0; i < 3; i++) begin
				cmp_buf_reg[i] <= tmr16_pkg::BOTTOM_VAL;
				cmp_act_reg[i] <= tmr16_pkg::BOTTOM_VAL;
			end
			temp_reg    <= 8'h00;
			flag_reg    <= 8'h00;
			mask_reg    <= 8'h00;
			power_reg   <= tmr16_pkg::POWER_RST;
			rdata_reg   <= 8'h00;
			irq_reg     <= 8'h00;
			pin_reg     <= 3'h0;
			block_reg   <= 1'b0;
			dir_reg     <= tmr16_pkg::TMR16_UP;
		end else begin
			ctrl_a_reg  <= ctrl_a_next;
			ctrl_b_reg  <= ctrl_b_next;
			ctrl_c_reg  <= ctrl_c_next;
			count_reg   <= count_next;
			capture_reg <= capture_next;
			cmp_buf_reg <= cmp_buf_next;
			cmp_act_reg <= cmp_act_next;
			temp_reg    <= temp_next;
			flag_reg    <= flag_next;
			mask_reg    <= mask_next;
			power_reg   <= power_next;
			rdata_reg   <= rdata_next;
			irq_reg     <= irq_next;
			pin_reg     <= pin_next;
			block_reg   <= block_next;
			dir_reg     <= dir_next;
		end
	end

	assign rdata_out            = rdata_reg;
	assign irq_req_out          = irq_reg;
	assign compare_out_pins_out = pin_reg;
	assign count_bottom_out     = count_reg == tmr16_pkg::BOTTOM_VAL;
	assign count_max_out        = count_reg == tmr16_pkg::MAX_VAL;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!arst_n_in);

	sequence lo_write_s;
		wr_in && addr_in == tmr16_pkg::CNT_L;
	endsequence
	sequence hi_write_s;
		wr_in && addr_in == tmr16_pkg::CMPB_H;
	endsequence

	count_hold_a: assert property (!run && !cnt_wr |=> $stable(count_reg))
		else $error("counter moved without tick");
	count_write_a: assert property (lo_write_s |=> count_reg == {$past(temp_reg), $past(wdata_in)})
		else $error("counter write lost or merged wrong");
	pair_write_a: assert property (hi_write_s ##1 (wr_in && addr_in == tmr16_pkg::CMPB_L)
		|=> cmp_buf_reg[1] == {$past(wdata_in, 2), $past(wdata_in)})
		else $error("high then low write mismatch");
	hi_only_a: assert property (hi_write_s |=> $stable(cmp_buf_reg[1]) && temp_reg == $past(wdata_in))
		else $error("high byte write reached target");
	lo_read_a: assert property (rd_in && addr_in == tmr16_pkg::CNT_L
		|=> rdata_out == $past(count_reg[7:0]) && temp_reg == $past(count_reg[15:8]))
		else $error("low read did not latch high byte");
	cmp_read_a: assert property (rd_in && addr_in == tmr16_pkg::CMPA_H
		|=> rdata_out == $past(cmp_buf_reg[0][15:8]) && $stable(temp_reg))
		else $error("compare read touched temporary");
	ovf_wrap_a: assert property (run && !dual && !cnt_wr && count_reg == top_val
		|=> flag_reg[tmr16_pkg::FL_OVF] && count_reg == tmr16_pkg::BOTTOM_VAL)
		else $error("no wrap or overflow at top");
	match_flag_a: assert property (match[1] |=> flag_reg[tmr16_pkg::FL_CMPA + 1])
		else $error("match flag not set");
	capture_take_a: assert property (cap_ok |=> capture_reg == $past(count_reg) && flag_reg[tmr16_pkg::FL_CAP])
		else $error("capture missed");
	irq_gate_a: assert property (irq_req_out == (flag_reg & mask_reg))
		else $error("request not gated by mask");
	pwm_a_off_a: assert property (compare_out_pins_out[0] |-> !$past(pwm && top_sel == tmr16_pkg::TOP_CMPA))
		else $error("channel a output while top");
endmodule // tmr16_core

/* File: verif/tmr16_cpu_model.sv */
// processor side bus master model for the timer core
`timescale 1ns/1ps
module tmr16_cpu_model (
	input  wire logic       clk_sys_in,
	input  wire logic [7:0] rdata_in,
	output logic      [4:0] addr_out,
	output logic      [7:0] wdata_out,
	output logic            wr_out,
	output logic            rd_out
);
	initial begin
		addr_out = 5'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	////////////////////////////////////////////////////////////
	task automatic wr8(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_sys_in);
		wr_out <= 1'b0;
		wdata_out <= ~d;
	endtask
	task automatic rd8(input logic [4:0] a, output logic [7:0] d);
		@(posedge clk_sys_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_sys_in);
		rd_out <= 1'b0;
		@(negedge clk_sys_in);
		d = rdata_in;
	endtask
	// byte pair issued with nothing in between
	task automatic wr16(input logic [4:0] a, input logic [15:0] v);
		@(posedge clk_sys_in);
		addr_out <= a + 5'h01;
		wdata_out <= v[15:8];
		wr_out <= 1'b1;
		@(posedge clk_sys_in);
		addr_out <= a;
		wdata_out <= v[7:0];
		@(posedge clk_sys_in);
		wr_out <= 1'b0;
		wdata_out <= ~v[7:0];
	endtask
	task automatic rd16(input logic [4:0] a, output logic [15:0] v);
		rd8(a, v[7:0]);
		rd8(a + 5'h01, v[15:8]);
	endtask
endmodule // tmr16_cpu_model

/* File: verif/sixteen_bit_timer_access_core_tb.sv */
// self-checking bench for the timer core
`timescale 1ns/1ps
module sixteen_bit_timer_access_core_tb;
	logic        clk_sys_in = 1'b0;
	logic        arst_n_in = 1'b0;
	logic [4:0]  addr;
	logic [7:0]  wdata;
	logic        wr;
	logic        rd;
	logic [7:0]  rdata;
	logic        ext_pin;
	logic        cap_pin;
	logic        cmp_pin;
	logic [2:0]  pins;
	logic [7:0]  irq;
	logic        bottom;
	logic        max;
	int          mismatches = 0;
	int          checks = 0;
	logic [15:0] v;
	logic [7:0]  b;
	logic [2:0]  tsel [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
	logic [15:0] topv [6] = '{16'hffff, 16'h00ff, 16'h01ff, 16'h03ff, 16'h0040, 16'h0080};

	always #25 clk_sys_in = ~clk_sys_in;

	tmr16_core u_tmr16_core (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .ext_count_pin_in(ext_pin),
		.capture_pin_in(cap_pin), .comparator_in(cmp_pin), .compare_out_pins_out(pins),
		.irq_req_out(irq), .count_bottom_out(bottom), .count_max_out(max));
	tmr16_cpu_model u_tmr16_cpu_model (.clk_sys_in(clk_sys_in), .rdata_in(rdata), .addr_out(addr),
		.wdata_out(wdata), .wr_out(wr), .rd_out(rd));
	////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic w8(input logic [4:0] a, input logic [7:0] d);
		u_tmr16_cpu_model.wr8(a, d);
	endtask
	task automatic w16(input logic [4:0] a, input logic [15:0] d);
		u_tmr16_cpu_model.wr16(a, d);
	endtask
	task automatic r16(input logic [4:0] a);
		u_tmr16_cpu_model.rd16(a, v);
	endtask
	task automatic wait_flag(input int n);
		int k;
		k = 0;
		b = 8'h00;
		while (b[n] !== 1'b1) begin
			u_tmr16_cpu_model.rd8(tmr16_pkg::FLAG, b);
			k++;
			if (k > 300) begin
				mismatches++;
				close_out();
			end
		end
	endtask
	initial begin
		#2500000;
		mismatches++;
		close_out();
	end
	////////////////////////////////////////////////////////////
	initial begin
		ext_pin = 1'b0;
		cap_pin = 1'b0;
		cmp_pin = 1'b0;
		repeat (16) @(posedge clk_sys_in);
		arst_n_in <= 1'b1;
		check("bottom at reset", bottom, 1'b1);
		r16(tmr16_pkg::CNT_L);
		check("count reset", v, 16'h0000);
		w8(5'h1f, 8'hff);
		u_tmr16_cpu_model.rd8(5'h1f, b);
		check("unmapped", b, 8'h00);
		w8(tmr16_pkg::POWER, 8'h00);
		// stopped counter, byte ordered access through the shared temp byte
		w16(tmr16_pkg::CNT_L, 16'h01ff);
		repeat (20) @(posedge clk_sys_in);
		r16(tmr16_pkg::CNT_L);
		check("count hold", v, 16'h01ff);
		w8(tmr16_pkg::CNT_H, 8'hab);
		u_tmr16_cpu_model.rd8(tmr16_pkg::CNT_H, b);
		check("count high is temp", b, 8'hab);
		r16(tmr16_pkg::CNT_L);
		check("high write alone", v, 16'h01ff);
		w16(tmr16_pkg::CMPA_L, 16'h1234);
		w8(tmr16_pkg::CMPB_L, 8'h56);
		r16(tmr16_pkg::CMPB_L);
		check("temp shared", v, 16'h1256);
		u_tmr16_cpu_model.rd8(tmr16_pkg::CNT_L, b);
		u_tmr16_cpu_model.rd8(tmr16_pkg::CMPA_H, b);
		check("compare high direct", b, 8'h12);
		w16(tmr16_pkg::CNT_L, 16'hffff);
		@(negedge clk_sys_in);
		check("max flag", {bottom, max}, 2'b01);
		// external pin clocking, rising then falling edges
		for (int m = 0; m < 2; m++) begin
			w16(tmr16_pkg::CNT_L, 16'h0000);
			w8(tmr16_pkg::CTRL_B, m ? 8'h06 : 8'h07);
			repeat (5) begin
				@(posedge clk_sys_in) ext_pin <= 1'b1;
				repeat (4) @(posedge clk_sys_in);
				ext_pin <= 1'b0;
				repeat (4) @(posedge clk_sys_in);
			end
			w8(tmr16_pkg::CTRL_B, 8'h00);
			r16(tmr16_pkg::CNT_L);
			check("ext edges", v, 16'h0005);
		end
		// every top selection wraps the count and flags overflow
		for (int k = 0; k < 6; k++) begin
			w8(tmr16_pkg::CTRL_A, {5'h00, tsel[k]});
			w16(tmr16_pkg::CMPA_L, 16'h0040);
			w16(tmr16_pkg::CAP_L, 16'h0080);
			w16(tmr16_pkg::CNT_L, topv[k] - 16'h0003);
			w8(tmr16_pkg::FLAG, 8'hff);
			w8(tmr16_pkg::CTRL_B, tmr16_pkg::CS_DIV1);
			wait_flag(tmr16_pkg::FL_OVF);
			w8(tmr16_pkg::CTRL_B, 8'h00);
			r16(tmr16_pkg::CNT_L);
			check("wrap at top", v < 16'h0020, 1'b1);
		end
		// match flag, mask gating and compare pin
		w8(tmr16_pkg::CTRL_A, 8'h00);
		w8(tmr16_pkg::MASK, 8'h00);
		w16(tmr16_pkg::CMPB_L, 16'h0010);
		w16(tmr16_pkg::CNT_L, 16'h0000);
		w8(tmr16_pkg::FLAG, 8'hff);
		w8(tmr16_pkg::CTRL_B, tmr16_pkg::CS_DIV1);
		wait_flag(2);
		w8(tmr16_pkg::CTRL_B, 8'h00);
		check("masked", irq[2], 1'b0);
		w8(tmr16_pkg::MASK, 8'h04);
		@(negedge clk_sys_in);
		check("irq b", irq, 8'h04);
		check("pin b toggled", pins[1], 1'b1);
		// capture from the pin, then from the comparator through the filter
		for (int s = 0; s < 2; s++) begin
			w8(tmr16_pkg::CTRL_B, s ? 8'hc0 : 8'h40);
			w8(tmr16_pkg::CTRL_C, s[7:0]);
			w16(tmr16_pkg::CNT_L, 16'h1234 + s[15:0]);
			w8(tmr16_pkg::FLAG, 8'hff);
			@(posedge clk_sys_in);
			if (s == 0) cap_pin <= 1'b1;
			else cmp_pin <= 1'b1;
			repeat (14) @(posedge clk_sys_in);
			r16(tmr16_pkg::CAP_L);
			check("capture", v, 16'h1234 + s[15:0]);
			u_tmr16_cpu_model.rd8(tmr16_pkg::FLAG, b);
			check("capture flag", b[5], 1'b1);
		end
		// prescaler tap, dual slope turn at the top, pwm levels
		w16(tmr16_pkg::CNT_L, 16'h0000);
		w8(tmr16_pkg::CTRL_B, {5'h00, tmr16_pkg::CS_DIV8});
		repeat (80) @(posedge clk_sys_in);
		w8(tmr16_pkg::CTRL_B, 8'h00);
		r16(tmr16_pkg::CNT_L);
		check("prescale 8", v >= 16'h0009 && v <= 16'h000b, 1'b1);
		w8(tmr16_pkg::CTRL_A, 8'h11);
		w16(tmr16_pkg::CNT_L, 16'h00fc);
		w8(tmr16_pkg::CTRL_B, {5'h00, tmr16_pkg::CS_DIV1});
		repeat (6) @(posedge clk_sys_in);
		w8(tmr16_pkg::CTRL_B, 8'h00);
		r16(tmr16_pkg::CNT_L);
		check("dual turn", v > 16'h00e0 && v < 16'h00ff, 1'b1);
		w8(tmr16_pkg::CTRL_A, 8'h00);
		w16(tmr16_pkg::CMPA_L, 16'h0080);
		w16(tmr16_pkg::CMPB_L, 16'h0080);
		for (int p = 0; p < 2; p++) begin
			w8(tmr16_pkg::CTRL_A, p ? 8'h0c : 8'h08);
			w16(tmr16_pkg::CNT_L, p ? 16'h0010 : 16'h00a0);
			repeat (2) @(negedge clk_sys_in);
			check("pwm a off", pins[0], 1'b0);
			check("pwm b level", pins[1], p[0]);
		end
		// power gate freezes counting
		w8(tmr16_pkg::POWER, 8'h01);
		w16(tmr16_pkg::CNT_L, 16'h0100);
		w8(tmr16_pkg::CTRL_B, tmr16_pkg::CS_DIV1);
		repeat (20) @(posedge clk_sys_in);
		w8(tmr16_pkg::CTRL_B, 8'h00);
		r16(tmr16_pkg::CNT_L);
		check("gated", v, 16'h0100);
		close_out();
	end
endmodule // sixteen_bit_timer_access_core_tb
